// [sim/rhr_host_model.sv]
// host processor model driving the register command port
`default_nettype none

module rhr_host_model (
  // clock
  input wire logic clk_i,
  // command port
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [31:0] cmd_wdata_o,
  input wire logic [31:0] cmd_rdata_i,
  input wire logic cmd_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle port at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 32'h0000_0000;
  end

  // one command for one clock, then stale lines scrambled
  task automatic issue(input logic [7:0] code, input logic [31:0] data);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    cmd_wdata_o = data;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
    cmd_wdata_o = ~data;
  endtask

  // write; status writes carry zeros in reserved bits
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    logic [31:0] w;
    w = data;
    if (code == rhr_pkg::CMD_STAT_WR) begin
      w = data & 32'h8003_8001;
    end
    issue(code, w);
    @(negedge clk_i);
  endtask

  // write, then read on the very next clock with the strobe held high
  task automatic wr_rd(input logic [7:0] wcode, input logic [31:0] wdat,
                       input logic [7:0] rcode, output logic [31:0] data,
                       output logic ok);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = wcode;
    cmd_wdata_o = (wcode == rhr_pkg::CMD_STAT_WR) ?
      (wdat & 32'h8003_8001) : wdat;
    @(negedge clk_i);
    cmd_code_o = rcode;
    cmd_wdata_o = 32'h0000_0000;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    ok = (cmd_rvalid_i === 1'b1);
    data = cmd_rdata_i;
  endtask

  // read; bounded wait for the one-cycle answer
  task automatic rd(input logic [7:0] code, output logic [31:0] data,
                    output logic ok);
    ok = 1'b0;
    data = 32'h0000_0000;
    issue(code, 32'h0000_0000);
    // the answer stands only at the negedge that ends the command
    for (int i = 0; i < 4 && !ok; i++) begin
      if (cmd_rvalid_i === 1'b1) begin
        ok = 1'b1;
        data = cmd_rdata_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask
endmodule

`default_nettype wire

// [sim/tb_rhr_regs.sv]
// self-checking testbench of the root hub register block
`default_nettype none

module tb_rhr_regs;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i, rstn_i, oper, psel, oc;
  logic cmd_valid, rvalid, wake;
  logic [7:0] cmd_code;
  logic [31:0] wdata, rdata;
  logic [1:0] pset, pclr, power, removable, mask;
  int error_cnt, n_tests;

  // clock and time-zero values
  initial begin
    {rstn_i, oper, psel, oc, pset, pclr} = '0;
    error_cnt = 0;
    n_tests = 0;
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  rhr_host_model rhr_host_model_i (.clk_i(clk_i), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_wdata_o(wdata), .cmd_rdata_i(rdata),
    .cmd_rvalid_i(rvalid));

  rhr_regs rhr_regs_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_wdata_i(wdata),
    .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid), .usb_operational_i(oper),
    .power_switch_select_i(psel), .overcurrent_i(oc),
    .port_pwr_set_i(pset), .port_pwr_clr_i(pclr), .port_power_o(power),
    .device_removable_bits_o(removable), .port_power_mask_o(mask),
    .remote_wakeup_enable_o(wake));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // verdict and end of run
  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read a register and compare the word
  task automatic rdc(input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    rhr_host_model_i.rd(code, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("Error rvalid expected 1 seen 0");
      stop_test();
    end else begin
      chk("read word", d, exp);
    end
  endtask

  // write and read back on consecutive clocks, compare the word
  task automatic wrc(input logic [7:0] wc, input logic [31:0] wd,
                     input logic [7:0] rc, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    rhr_host_model_i.wr_rd(wc, wd, rc, d, ok);
    chk("rvalid", {31'h0, ok}, 32'h1);
    chk("read word", d, exp);
  endtask

  // one-cycle per-port power pulses
  task automatic pulse(input logic [1:0] s, input logic [1:0] c);
    @(negedge clk_i);
    pset = s;
    pclr = c;
    @(negedge clk_i);
    pset = 2'h0;
    pclr = 2'h0;
    @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    rdc(rhr_pkg::CMD_DESCB_RD, 32'h0000_0000);
    rdc(rhr_pkg::CMD_STAT_RD, 32'h0000_0000);
    // descriptor writable while not operational, reserved bits dropped
    rhr_host_model_i.wr(rhr_pkg::CMD_DESCB_WR, 32'hffff_ffff);
    chk("mask", {30'h0, mask}, 32'h3);
    chk("removable", {30'h0, removable}, 32'h3);
    rdc(rhr_pkg::CMD_DESCB_RD, 32'h0006_0006);
    // back-to-back write and read, port one masked
    wrc(rhr_pkg::CMD_DESCB_WR, 32'h0002_0002, rhr_pkg::CMD_DESCB_RD,
        32'h0002_0002);
    // status write refused until operational
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0000_8000);
    chk("wake", {31'h0, wake}, 32'h0);
    oper = 1'b1;
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0000_8000);
    chk("wake", {31'h0, wake}, 32'h1);
    rdc(rhr_pkg::CMD_STAT_RD, 32'h0000_8000);
    wrc(rhr_pkg::CMD_STAT_WR, 32'h0000_8000, rhr_pkg::CMD_STAT_RD,
        32'h0000_8000);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h8000_0000);
    chk("wake", {31'h0, wake}, 32'h0);
    // global mode: mask ignored, pulses ignored
    pulse(2'h3, 2'h0);
    chk("power", {30'h0, power}, 32'h0);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0001_0000);
    chk("power", {30'h0, power}, 32'h3);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0000_0001);
    chk("power", {30'h0, power}, 32'h0);
    // per-port mode, port two masked
    psel = 1'b1;
    rhr_host_model_i.wr(rhr_pkg::CMD_DESCB_WR, 32'h0004_0000);
    chk("mask", {30'h0, mask}, 32'h2);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0001_0000);
    chk("power", {30'h0, power}, 32'h1);
    pulse(2'h3, 2'h0);
    chk("power", {30'h0, power}, 32'h3);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0000_0001);
    chk("power", {30'h0, power}, 32'h2);
    pulse(2'h0, 2'h3);
    chk("power", {30'h0, power}, 32'h0);
    // overcurrent: indicator low half, change flag high half
    oc = 1'b1;
    repeat (3) @(negedge clk_i);
    rdc(rhr_pkg::CMD_STAT_RD, 32'h0002_0002);
    rhr_host_model_i.wr(rhr_pkg::CMD_STAT_WR, 32'h0002_0000);
    rdc(rhr_pkg::CMD_STAT_RD, 32'h0000_0002);
    oc = 1'b0;
    repeat (3) @(negedge clk_i);
    rdc(rhr_pkg::CMD_STAT_RD, 32'h0002_0000);
    stop_test();
  end
endmodule

`default_nettype wire

// [src/rhr_pkg.sv]
// constants and state types of the root hub descriptor and status registers
//
// Contract
// - per-port mode: set mask bit means per-port only
// - clear mask bit: port follows global power commands
// - global mode ignores the port power mask
// - port power mask bits 18:16, bit 16 reserved
// - removable bit 0 reserved, bits 1,2 ports
// - status low half, change bits high half
// - status read 14h, write 94h, same register
// - descriptor read 13h, write 93h
// - every access moves one whole 32-bit word
// - descriptor writable always, status only when operational
`default_nettype none

package rhr_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_DESCB_RD = 8'h13; // descriptor read
  localparam logic [7:0] CMD_DESCB_WR = 8'h93; // descriptor write
  localparam logic [7:0] CMD_STAT_RD = 8'h14;  // hub status read
  localparam logic [7:0] CMD_STAT_WR = 8'h94;  // hub status write

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 2;        // downstream ports
  localparam int POS_PORT_MASK = 16;   // port_power_mask, bit 0 reserved
  localparam int POS_REMOVABLE = 0;    // device_removable_bits
  localparam int POS_CLR_WAKE = 31;    // clear_wakeup_enable
  localparam int POS_OC_CHG = 17;      // overcurrent_change_flag
  localparam int POS_SET_GLOBAL = 16;  // local_power_change_or_set_global
  localparam int POS_WAKE_EN = 15;     // remote_wakeup_enable
  localparam int POS_OC_IND = 1;       // overcurrent_indicator
  localparam int POS_CLR_GLOBAL = 0;   // local_power_or_clear_global

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0] RST_PORT_MASK = 2'h0;  // plain default
  localparam logic [NUM_PORTS-1:0] RST_REMOVABLE = 2'h0;  // plain default
  localparam logic [NUM_PORTS-1:0] RST_PORT_POWER = 2'h0; // ports off
  localparam logic [31:0] RST_WORD = 32'h0000_0000;       // read data

  // ---------------------------------------------------------------
  // state of the register module
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PORTS-1:0] port_mask;  // port_power_mask, ports 2..1
    logic [NUM_PORTS-1:0] removable;  // device_removable_bits
    logic wake_en;                    // remote_wakeup_enable
    logic oc_ind;                     // overcurrent_indicator
    logic oc_chg;                     // overcurrent_change_flag
    logic [31:0] rd_data;             // read word
    logic rd_valid;                   // read answer strobe
  } rhr_regs_t;

  // state of the power switch module
  typedef struct packed {
    logic [NUM_PORTS-1:0] power;      // power state per port
  } rhr_pwr_t;

endpackage

`default_nettype wire

// [src/rhr_port_power.sv]
// port power switch state, steered by global and per-port commands
`default_nettype none

module rhr_port_power (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // global commands, one-cycle pulses
  input wire logic glob_set_i,
  input wire logic glob_clr_i,
  // per-port commands, one-cycle pulses
  input wire logic [rhr_pkg::NUM_PORTS-1:0] port_set_i,
  input wire logic [rhr_pkg::NUM_PORTS-1:0] port_clr_i,
  // configuration
  input wire logic power_switch_select_i,
  input wire logic [rhr_pkg::NUM_PORTS-1:0] port_mask_i,
  // power state
  output logic [rhr_pkg::NUM_PORTS-1:0] port_power_o
);

  rhr_pkg::rhr_pwr_t s_q, s_d; // registered state and next value
  logic [rhr_pkg::NUM_PORTS-1:0] nxt; // per-port next power

  // ---------------------------------------------------------------
  // per-port power decision
  // ---------------------------------------------------------------
  for (genvar p = 0; p < rhr_pkg::NUM_PORTS; p++) begin : g_port
    logic glob_own; // port follows global commands
    logic set_p;    // power on request
    logic clr_p;    // power off request
    // global mode ignores the mask entirely
    assign glob_own = !power_switch_select_i || !port_mask_i[p];
    assign set_p = (glob_own && glob_set_i) ||
      (power_switch_select_i && port_mask_i[p] && port_set_i[p]);
    assign clr_p = (glob_own && glob_clr_i) ||
      (power_switch_select_i && port_mask_i[p] && port_clr_i[p]);
    // clear wins when both arrive together
    assign nxt[p] = clr_p ? 1'b0 : (set_p ? 1'b1 : s_q.power[p]);
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.power = nxt;
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{power: rhr_pkg::RST_PORT_POWER};
    end else begin
      s_q <= s_d;
    end
  end

  assign port_power_o = s_q.power;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  global_all_a: assert property (
    !power_switch_select_i && glob_set_i && !glob_clr_i
      |=> &port_power_o)
    else $error("global set did not power all ports");
  mask_ignore_a: assert property (
    power_switch_select_i && port_mask_i[1] && glob_clr_i &&
      !port_clr_i[1] && !port_set_i[1]
      |=> port_power_o[1] == $past(port_power_o[1]))
    else $error("masked port followed a global clear");
  ganged_off_a: assert property (
    power_switch_select_i && !port_mask_i[0] && glob_clr_i
      |=> !port_power_o[0])
    else $error("unmasked port ignored a global clear");
  cover_global_on_c: cover property (!power_switch_select_i && glob_set_i);

endmodule

`default_nettype wire

// [src/rhr_regs.sv]
// root hub descriptor and hub status registers behind the command port
`default_nettype none

module rhr_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // command port from the host processor
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  // controller state
  input wire logic usb_operational_i,
  input wire logic power_switch_select_i,
  // global overcurrent level
  input wire logic overcurrent_i,
  // per-port power commands from the port status logic
  input wire logic [rhr_pkg::NUM_PORTS-1:0] port_pwr_set_i,
  input wire logic [rhr_pkg::NUM_PORTS-1:0] port_pwr_clr_i,
  // outputs to the hub
  output logic [rhr_pkg::NUM_PORTS-1:0] port_power_o,
  output logic [rhr_pkg::NUM_PORTS-1:0] device_removable_bits_o,
  output logic [rhr_pkg::NUM_PORTS-1:0] port_power_mask_o,
  output logic remote_wakeup_enable_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  rhr_pkg::rhr_regs_t s_q, s_d; // registered state and next value
  logic wr_descb; // descriptor write strobe
  logic wr_stat;  // accepted status write strobe
  logic rd_descb; // descriptor read strobe
  logic rd_stat;  // status read strobe
  logic glob_set; // set global power command
  logic glob_clr; // clear global power command
  logic [31:0] descb_word; // descriptor read image
  logic [31:0] stat_word;  // status read image

  // one code per direction, both aimed at the same register
  assign wr_descb = cmd_valid_i && cmd_code_i == rhr_pkg::CMD_DESCB_WR;
  assign rd_descb = cmd_valid_i && cmd_code_i == rhr_pkg::CMD_DESCB_RD;
  // status writes outside the operational state are dropped
  assign wr_stat = cmd_valid_i && cmd_code_i == rhr_pkg::CMD_STAT_WR &&
    usb_operational_i;
  assign rd_stat = cmd_valid_i && cmd_code_i == rhr_pkg::CMD_STAT_RD;

  // power commands ride on write-one bits of the status word
  assign glob_set = wr_stat && cmd_wdata_i[rhr_pkg::POS_SET_GLOBAL];
  assign glob_clr = wr_stat && cmd_wdata_i[rhr_pkg::POS_CLR_GLOBAL];

  // ---------------------------------------------------------------
  // read images
  // ---------------------------------------------------------------
  // reserved positions, including bit 0 of each field, read zero
  always_comb begin
    descb_word = rhr_pkg::RST_WORD;
    descb_word[rhr_pkg::POS_PORT_MASK+1 +: rhr_pkg::NUM_PORTS] =
      s_q.port_mask;
    descb_word[rhr_pkg::POS_REMOVABLE+1 +: rhr_pkg::NUM_PORTS] =
      s_q.removable;
  end

  // status in the low half, change bits in the high half
  always_comb begin
    stat_word = rhr_pkg::RST_WORD;
    stat_word[rhr_pkg::POS_OC_CHG] = s_q.oc_chg;
    stat_word[rhr_pkg::POS_WAKE_EN] = s_q.wake_en;
    stat_word[rhr_pkg::POS_OC_IND] = s_q.oc_ind;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // descriptor takes a whole word, reserved bits dropped
    if (wr_descb) begin
      s_d.port_mask = cmd_wdata_i[rhr_pkg::POS_PORT_MASK+1 +:
        rhr_pkg::NUM_PORTS];
      s_d.removable = cmd_wdata_i[rhr_pkg::POS_REMOVABLE+1 +:
        rhr_pkg::NUM_PORTS];
    end
    // wakeup enable: set bit 15, clear bit 31, clear wins
    if (wr_stat && cmd_wdata_i[rhr_pkg::POS_WAKE_EN]) begin
      s_d.wake_en = 1'b1;
    end
    if (wr_stat && cmd_wdata_i[rhr_pkg::POS_CLR_WAKE]) begin
      s_d.wake_en = 1'b0;
    end
    // overcurrent level tracked, change flag write-one-clear
    s_d.oc_ind = overcurrent_i;
    if (wr_stat && cmd_wdata_i[rhr_pkg::POS_OC_CHG]) begin
      s_d.oc_chg = 1'b0;
    end
    // a fresh change beats a clear in the same cycle
    if (overcurrent_i != s_q.oc_ind) begin
      s_d.oc_chg = 1'b1;
    end
    // whole-word read answer one cycle after the command
    s_d.rd_valid = rd_descb || rd_stat;
    if (rd_descb) begin
      s_d.rd_data = descb_word;
    end else if (rd_stat) begin
      s_d.rd_data = stat_word;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{port_mask: rhr_pkg::RST_PORT_MASK,
               removable: rhr_pkg::RST_REMOVABLE,
               wake_en: 1'b0, oc_ind: 1'b0, oc_chg: 1'b0,
               rd_data: rhr_pkg::RST_WORD, rd_valid: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // power switching
  // ---------------------------------------------------------------
  rhr_port_power u_power (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .glob_set_i(glob_set),
    .glob_clr_i(glob_clr),
    .port_set_i(port_pwr_set_i),
    .port_clr_i(port_pwr_clr_i),
    .power_switch_select_i(power_switch_select_i),
    .port_mask_i(s_q.port_mask),
    .port_power_o(port_power_o)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cmd_rdata_o = s_q.rd_data;
  assign cmd_rvalid_o = s_q.rd_valid;
  assign device_removable_bits_o = s_q.removable;
  assign port_power_mask_o = s_q.port_mask;
  assign remote_wakeup_enable_o = s_q.wake_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  descb_roundtrip_a: assert property (
    wr_descb ##1 rd_descb |=> cmd_rvalid_o &&
      cmd_rdata_o[18:17] == $past(cmd_wdata_i[18:17], 2) &&
      cmd_rdata_o[2:1] == $past(cmd_wdata_i[2:1], 2))
    else $error("descriptor read back differs from write");
  reserved_zero_a: assert property (
    rd_descb |=> cmd_rdata_o[31:19] == 13'h0000 &&
      cmd_rdata_o[16:3] == 14'h0000 && !cmd_rdata_o[0])
    else $error("descriptor reserved bits not zero");
  stat_image_a: assert property (
    rd_stat |=> cmd_rdata_o[17] == $past(s_q.oc_chg) &&
      cmd_rdata_o[15] == $past(s_q.wake_en) &&
      cmd_rdata_o[1] == $past(s_q.oc_ind) &&
      cmd_rdata_o[31:18] == 14'h0000 && cmd_rdata_o[16] == 1'b0)
    else $error("status read image wrong");
  stat_locked_a: assert property (
    cmd_valid_i && cmd_code_i == 8'h94 && !usb_operational_i &&
      !(overcurrent_i != s_q.oc_ind)
      |=> $stable(s_q.wake_en) && $stable(s_q.oc_chg))
    else $error("status changed by write outside operational");
  stat_code_a: assert property (
    cmd_valid_i && cmd_code_i == 8'h94 && usb_operational_i &&
      cmd_wdata_i[15] && !cmd_wdata_i[31] ##1 cmd_valid_i &&
      cmd_code_i == 8'h14 |=> cmd_rdata_o[15])
    else $error("status write not seen by status read");
  oc_change_a: assert property (
    overcurrent_i != s_q.oc_ind |=> s_q.oc_chg [*1])
    else $error("overcurrent change not flagged");
  read_once_a: assert property (
    !(rd_descb || rd_stat) |=> !cmd_rvalid_o)
    else $error("read answer without request");
  removable_out_a: assert property (
    wr_descb |=> device_removable_bits_o == $past(cmd_wdata_i[2:1]))
    else $error("removable bits not taken from write");

  cover_descb_c: cover property (wr_descb ##1 rd_descb);
  cover_stat_c: cover property (wr_stat && cmd_wdata_i[16]);
  cover_oc_c: cover property (overcurrent_i != s_q.oc_ind);

endmodule

`default_nettype wire
